// *** design/fepseq_pkg.sv ***
package fepseq_pkg;

  // register pages and offsets on the cpu bus
  localparam logic [15:0] FEPSEQ_REG_PAGE_PROG = 16'hFFF9;
  localparam logic [15:0] FEPSEQ_REG_PAGE_DATA = 16'hFFF7;
  localparam logic [7:0] FEPSEQ_OFS_IBAR = 8'h40;
  localparam logic [7:0] FEPSEQ_OFS_IBDR = 8'h42;
  localparam logic [7:0] FEPSEQ_OFS_WER0 = 8'h44;
  localparam logic [7:0] FEPSEQ_OFS_WER1 = 8'h46;
  localparam logic [7:0] FEPSEQ_OFS_CTRL = 8'h4C;
  localparam logic [7:0] FEPSEQ_OFS_STAT = 8'h4E;
  localparam logic [7:0] FEPSEQ_OFS_AR0 = 8'h64;
  localparam logic [7:0] FEPSEQ_OFS_AR1 = 8'h66;

  // control and status bit positions
  localparam int FEPSEQ_CTRL_PE = 0;
  localparam int FEPSEQ_CTRL_PER = 1;
  localparam int FEPSEQ_CTRL_MER = 2;
  localparam int FEPSEQ_STAT_BUSY = 0;
  localparam int FEPSEQ_STAT_FULL = 1;
  localparam int FEPSEQ_STAT_ERASE_FAIL_FLAG = 2;
  localparam int FEPSEQ_STAT_PROGRAM_FAIL_FLAG = 3;

  // main block 2 address tag (bits 23:13) and geometry
  localparam logic [10:0] FEPSEQ_MAIN2_TAG = 11'h070;
  localparam int FEPSEQ_PAGE_BITS_PROG = 10;
  localparam int FEPSEQ_PAGE_BITS_DATA = 9;
  localparam int FEPSEQ_SECT_LSB_PROG = 13;
  localparam int FEPSEQ_SECT_LSB_DATA = 9;
  localparam int FEPSEQ_KB_BITS = 10;
  localparam int FEPSEQ_IBA_SEL = 7;

  // dedicated information block words
  localparam logic [7:0] FEPSEQ_FUNC_WORD_ADDR = 8'h7E;
  localparam logic [7:0] FEPSEQ_PROT_WORD_ADDR = 8'hFE;

  // protection word field positions, each field 3 bits
  localparam int FEPSEQ_BOOT_LSB = 0;
  localparam int FEPSEQ_EMPTY_LSB = 3;
  localparam int FEPSEQ_BOOT_CONTENT_FIELD_LSB = 6;
  localparam int FEPSEQ_GLOBAL_READ_LOCK_FIELD_LSB = 9;
  localparam int FEPSEQ_GLOBAL_WRITE_LOCK_FIELD_LSB = 12;

  typedef enum logic [1:0] {
    FEPSEQ_OP_READ,
    FEPSEQ_OP_PROG,
    FEPSEQ_OP_PERASE,
    FEPSEQ_OP_MERASE
  } fepseq_op_t;

  typedef enum logic [2:0] {
    ST_LOAD_FUNC,
    ST_WAIT_FUNC,
    ST_WAIT_PROT,
    ST_RUN,
    ST_READ
  } fepseq_st_t;

  typedef struct packed {
    logic req;
    logic we;
    logic byte_rd;
    logic [23:0] addr;
    logic [15:0] wdata;
  } fepseq_bus_req_t;

  typedef struct packed {
    logic ack;
    logic [15:0] rdata;
  } fepseq_bus_rsp_t;

  // array request; valid is the start strobe, also used as queue slot
  typedef struct packed {
    logic valid;
    fepseq_op_t op;
    logic info;
    logic [17:0] addr;
    logic [15:0] wdata;
  } fepseq_arr_req_t;

  typedef struct packed {
    logic done;
    logic fail;
    logic [15:0] rdata;
  } fepseq_arr_rsp_t;

  typedef struct packed {
    logic hold_reset;
    logic isp_mode;
    logic [23:0] start_addr;
  } fepseq_boot_t;

  typedef struct packed {
    fepseq_st_t st;
    fepseq_bus_rsp_t bus;
    fepseq_arr_req_t [1:0] arr;
    fepseq_boot_t boot;
    logic [1:0][2:0] ctrl;
    logic [1:0] busy;
    logic [1:0] erasing;
    logic [1:0] erase_fail_flag;
    logic [1:0] program_fail_flag;
    fepseq_arr_req_t [1:0] pend;
    logic [1:0][7:0] ibar;
    logic [1:0][15:0] ibdr;
    logic [2:0][15:0] wer;
    logic [15:0] ar0;
    logic [15:0] ar1;
    logic env_low;
    logic env_high;
    logic dbg;
    logic rd_f;
    logic rd_byte;
    logic rd_hi;
    logic rd_info;
  } fepseq_state_t;

endpackage

// *** design/fepseq_top.sv ***
// Function
// - program reads wait for program busy; data reads wait for both; byte and word reads
// - info reads are word only; address register then data register read
// - erase sets region to ones; page erase needs section enable, never boot area
// - erase page is 1024 bytes in program blocks, 512 bytes in data block
// - main write with erase bit set starts erase; busy until done; fail flag
// - module erase needs all section enables, refused when block holds boot area
// - info erase also erases main block; refused for info block zero; no info page erase
// - info erase starts on data register write with module erase set
// - main programming needs global unlock and section enable; info programming only global unlock; boot area never programmed
// - program write starts pipelined job with busy; full set if one still running
// - info word programmed by address then data write; info block zero never written
// - at reset function word goes to auto read zero, protection word to one
// - boot area size is inverted three bit field times 1024; code follows it
// - programming mode start with no boot area keeps cpu in reset
// - blank indicator decoded by majority; set majority means empty
// - programming mode if both selects high and blank, or low select low high select high
// - boot content field majority set means programming routines in boot area
// - debug start ignores blank indicator and starts at address zero
// - majority clear write lock field blocks all cpu flash writes
// - clear full flag means pipeline takes a new word
// - protection word writes take effect only after next reset
`timescale 1ns/1ns
module fepseq_top (
  input logic i_clock,
  input logic i_nrst,
  input fepseq_pkg::fepseq_bus_req_t i_bus,
  output fepseq_pkg::fepseq_bus_rsp_t o_bus,
  input fepseq_pkg::fepseq_arr_rsp_t [1:0] i_arr,
  output fepseq_pkg::fepseq_arr_req_t [1:0] o_arr,
  input logic i_boot_select_low,
  input logic i_boot_select_high,
  input logic i_debug_boot_mode,
  output fepseq_pkg::fepseq_boot_t o_boot
);
  import fepseq_pkg::*;

  fepseq_state_t s;
  fepseq_state_t n;

  // majority of three bits
  function automatic logic maj3(input logic [2:0] v);
    maj3 = (v[0] & v[1]) | (v[0] & v[2]) | (v[1] & v[2]);
  endfunction

  // read permission: data flash needs both idle
  function automatic logic rd_gate(input logic ff, input logic [1:0] sb);
    rd_gate = ff ? !(|sb) : !sb[0];
  endfunction

  function automatic fepseq_arr_req_t mk_req(input fepseq_op_t op, input logic info,
                                             input logic [17:0] ad, input logic [15:0] wd);
    mk_req.valid = 1'b1;
    mk_req.op = op;
    mk_req.info = info;
    mk_req.addr = ad;
    mk_req.wdata = wd;
  endfunction

  // next-state logic
  always_comb begin
    fepseq_arr_req_t job;
    logic jf;
    logic jfl;
    logic ok;
    logic [23:0] a;
    logic m0;
    logic m2;
    logic f;
    logic rf;
    logic rf_hit;
    logic [7:0] ofs;
    logic [1:0] blk;
    logic [3:0] sec;
    logic [2:0] kb;
    logic boot_def;
    logic in_boot;
    logic wlock;
    logic [1:0] sbusy;
    logic [17:0] maddr;
    logic [2:0] c;
    logic [7:0] ia;
    logic info0;
    logic [15:0] rd;
    logic [15:0] r;
    logic [2:0] bk;
    logic emp;
    logic cont;
    logic in_system_programming_mode;
    n = s;
    job = '0;
    jf = 1'b0;
    jfl = 1'b0;
    ok = 1'b0;
    a = i_bus.addr;
    m0 = (a[23:18] == 6'h00);
    m2 = (a[23:13] == FEPSEQ_MAIN2_TAG);
    f = m2;
    rf = (a[23:8] == FEPSEQ_REG_PAGE_DATA);
    rf_hit = rf | (a[23:8] == FEPSEQ_REG_PAGE_PROG);
    ofs = a[7:0];
    blk = m2 ? 2'h2 : {1'b0, a[17]};
    sec = m2 ? a[FEPSEQ_SECT_LSB_DATA +: 4] : a[FEPSEQ_SECT_LSB_PROG +: 4];
    kb = ~s.ar1[FEPSEQ_BOOT_LSB +: 3];
    boot_def = (kb != 3'h0);
    in_boot = m0 && !a[17] && (a[16:FEPSEQ_KB_BITS] < {4'h0, kb});
    wlock = !maj3(s.ar1[FEPSEQ_GLOBAL_WRITE_LOCK_FIELD_LSB +: 3]);
    sbusy = s.busy | {s.pend[1].valid, s.pend[0].valid};
    maddr = m2 ? {5'h00, a[12:0]} : a[17:0];
    c = s.ctrl[f];
    ia = s.ibar[rf];
    info0 = !rf && !ia[FEPSEQ_IBA_SEL];
    r = 16'h0000;
    bk = 3'h0;
    emp = 1'b0;
    cont = 1'b0;
    in_system_programming_mode = 1'b0;
    n.bus.ack = 1'b0;
    n.arr[0].valid = 1'b0;
    n.arr[1].valid = 1'b0;

    // register read mux
    rd = 16'h0000;
    case (ofs)
      FEPSEQ_OFS_IBAR: rd = {8'h00, s.ibar[rf]};
      FEPSEQ_OFS_WER0: rd = rf ? s.wer[2] : s.wer[0];
      FEPSEQ_OFS_WER1: rd = rf ? 16'h0000 : s.wer[1];
      FEPSEQ_OFS_CTRL: rd = {13'h0000, s.ctrl[rf]};
      FEPSEQ_OFS_STAT: begin
        rd[FEPSEQ_STAT_BUSY] = sbusy[rf];
        rd[FEPSEQ_STAT_FULL] = s.pend[rf].valid;
        rd[FEPSEQ_STAT_ERASE_FAIL_FLAG] = s.erase_fail_flag[rf];
        rd[FEPSEQ_STAT_PROGRAM_FAIL_FLAG] = s.program_fail_flag[rf];
      end
      FEPSEQ_OFS_AR0: rd = rf ? 16'h0000 : s.ar0;
      FEPSEQ_OFS_AR1: rd = rf ? 16'h0000 : s.ar1;
      default: rd = 16'h0000;
    endcase

    case (s.st)
      // start-up: sample selects and fetch the function word
      ST_LOAD_FUNC: begin
        n.env_low = i_boot_select_low;
        n.env_high = i_boot_select_high;
        n.dbg = i_debug_boot_mode;
        n.arr[0] = mk_req(FEPSEQ_OP_READ, 1'b1, {10'h000, FEPSEQ_FUNC_WORD_ADDR}, 16'h0000);
        n.st = ST_WAIT_FUNC;
      end
      ST_WAIT_FUNC: begin
        if (i_arr[0].done) begin
          n.ar0 = i_arr[0].rdata;
          n.arr[0] = mk_req(FEPSEQ_OP_READ, 1'b1, {10'h000, FEPSEQ_PROT_WORD_ADDR}, 16'h0000);
          n.st = ST_WAIT_PROT;
        end
      end
      // protection word loaded only here, so later writes wait for reset
      ST_WAIT_PROT: begin
        if (i_arr[0].done) begin
          r = i_arr[0].rdata;
          n.ar1 = r;
          bk = ~r[FEPSEQ_BOOT_LSB +: 3];
          emp = maj3(r[FEPSEQ_EMPTY_LSB +: 3]) & !s.dbg;
          cont = maj3(r[FEPSEQ_BOOT_CONTENT_FIELD_LSB +: 3]);
          in_system_programming_mode = (s.env_low & s.env_high & emp) | (!s.env_low & s.env_high);
          n.boot.isp_mode = in_system_programming_mode;
          n.boot.hold_reset = in_system_programming_mode & ((bk == 3'h0) | !cont);
          n.boot.start_addr = (!s.dbg && cont) ? {11'h000, bk, 10'h000} : 24'h000000;
          n.st = ST_RUN;
        end
      end
      ST_RUN: begin
        if (i_bus.req && !s.bus.ack) begin
          if (rf_hit && !i_bus.we) begin
            // information block read through the data register
            if (ofs == FEPSEQ_OFS_IBDR) begin
              if (rd_gate(rf, sbusy)) begin
                n.arr[rf] = mk_req(FEPSEQ_OP_READ, 1'b1, {10'h000, ia}, 16'h0000);
                n.rd_f = rf;
                n.rd_byte = 1'b0;
                n.rd_hi = 1'b0;
                n.rd_info = 1'b1;
                n.st = ST_READ;
              end
            end else begin
              n.bus.ack = 1'b1;
              n.bus.rdata = rd;
            end
          end else if (rf_hit) begin
            n.bus.ack = 1'b1;
            n.bus.rdata = 16'h0000;
            case (ofs)
              FEPSEQ_OFS_IBAR: n.ibar[rf] = {i_bus.wdata[7:1], 1'b0};
              FEPSEQ_OFS_WER0: n.wer[rf ? 2 : 0] = i_bus.wdata;
              FEPSEQ_OFS_WER1: if (!rf) n.wer[1] = i_bus.wdata;
              FEPSEQ_OFS_CTRL: n.ctrl[rf] = i_bus.wdata[2:0];
              FEPSEQ_OFS_STAT: begin
                if (i_bus.wdata[FEPSEQ_STAT_ERASE_FAIL_FLAG]) n.erase_fail_flag[rf] = 1'b0;
                if (i_bus.wdata[FEPSEQ_STAT_PROGRAM_FAIL_FLAG]) n.program_fail_flag[rf] = 1'b0;
              end
              FEPSEQ_OFS_IBDR: begin
                jfl = rf;
                if (s.ctrl[rf][FEPSEQ_CTRL_MER]) begin
                  // info erase takes its main block along
                  ok = !wlock && !info0 && (&s.wer[rf ? 2 : 1]);
                  job = mk_req(FEPSEQ_OP_MERASE, 1'b1, {10'h000, ia}, 16'h0000);
                  n.bus.ack = ok ? 1'b0 : 1'b1;
                  jf = ok;
                  if (!ok) n.erase_fail_flag[rf] = 1'b1;
                end else if (s.ctrl[rf][FEPSEQ_CTRL_PER]) begin
                  n.erase_fail_flag[rf] = 1'b1;
                end else if (s.ctrl[rf][FEPSEQ_CTRL_PE]) begin
                  ok = !wlock && !info0;
                  job = mk_req(FEPSEQ_OP_PROG, 1'b1, {10'h000, ia}, i_bus.wdata);
                  n.bus.ack = ok ? 1'b0 : 1'b1;
                  jf = ok;
                  if (!ok) n.program_fail_flag[rf] = 1'b1;
                end else begin
                  n.ibdr[rf] = i_bus.wdata;
                end
              end
              default: n.ibdr = s.ibdr;
            endcase
          end else if ((m0 || m2) && !i_bus.we) begin
            if (rd_gate(f, sbusy)) begin
              n.arr[f] = mk_req(FEPSEQ_OP_READ, 1'b0, maddr, 16'h0000);
              n.rd_f = f;
              n.rd_byte = i_bus.byte_rd;
              n.rd_hi = a[0];
              n.rd_info = 1'b0;
              n.st = ST_READ;
            end
          end else if (m0 || m2) begin
            jfl = f;
            n.bus.ack = 1'b1;
            n.bus.rdata = 16'h0000;
            if (c[FEPSEQ_CTRL_MER]) begin
              ok = !wlock && (&s.wer[blk]) && !(blk == 2'h0 && boot_def);
              job = mk_req(FEPSEQ_OP_MERASE, 1'b0, maddr, 16'h0000);
              if (!ok) n.erase_fail_flag[f] = 1'b1;
            end else if (c[FEPSEQ_CTRL_PER]) begin
              ok = !wlock && s.wer[blk][sec] && !in_boot;
              job = mk_req(FEPSEQ_OP_PERASE, 1'b0, maddr, 16'h0000);
              if (m2) begin
                job.addr[FEPSEQ_PAGE_BITS_DATA-1:0] = '0;
              end else begin
                job.addr[FEPSEQ_PAGE_BITS_PROG-1:0] = '0;
              end
              if (!ok) n.erase_fail_flag[f] = 1'b1;
            end else if (c[FEPSEQ_CTRL_PE]) begin
              ok = !wlock && s.wer[blk][sec] && !in_boot;
              job = mk_req(FEPSEQ_OP_PROG, 1'b0, {maddr[17:1], 1'b0}, i_bus.wdata);
              if (!ok) n.program_fail_flag[f] = 1'b1;
            end
            jf = ok;
            if (ok) n.bus.ack = 1'b0;
          end else begin
            // unmapped address answers zero
            n.bus.ack = 1'b1;
            n.bus.rdata = 16'h0000;
          end
        end
      end
      // wait for the array read data
      ST_READ: begin
        if (i_arr[s.rd_f].done) begin
          r = i_arr[s.rd_f].rdata;
          n.bus.ack = 1'b1;
          n.bus.rdata = s.rd_byte ? {8'h00, s.rd_hi ? r[15:8] : r[7:0]} : r;
          if (s.rd_info) n.ibdr[s.rd_f] = r;
          n.st = ST_RUN;
        end
      end
      default: n.st = ST_LOAD_FUNC;
    endcase

    // accept a job: start now or park it in the queue slot
    if (jf) begin
      if (!s.busy[jfl]) begin
        n.arr[jfl] = job;
        n.busy[jfl] = 1'b1;
        n.erasing[jfl] = (job.op != FEPSEQ_OP_PROG);
        n.bus.ack = 1'b1;
      end else if (!s.pend[jfl].valid) begin
        n.pend[jfl] = job;
        n.bus.ack = 1'b1;
      end
    end

    // completion per flash; flag set wins over a clear in the same cycle
    for (int i = 0; i < 2; i++) begin
      if (s.busy[i] && i_arr[i].done) begin
        if (i_arr[i].fail && s.erasing[i]) n.erase_fail_flag[i] = 1'b1;
        if (i_arr[i].fail && !s.erasing[i]) n.program_fail_flag[i] = 1'b1;
        if (n.pend[i].valid) begin
          n.arr[i] = n.pend[i];
          n.erasing[i] = (n.pend[i].op != FEPSEQ_OP_PROG);
          n.pend[i].valid = 1'b0;
        end else begin
          n.busy[i] = 1'b0;
        end
      end
    end
  end

  // state register
  always_ff @(posedge i_clock) begin
    if (!i_nrst) begin
      s <= '0;
      s.boot.hold_reset <= 1'b1;
    end else begin
      s <= n;
    end
  end

  assign o_bus = s.bus;
  assign o_arr = s.arr;
  assign o_boot = s.boot;

endmodule

// *** verification/fepseq_flash_model.sv ***
`timescale 1ns/1ns
module fepseq_flash_model #(parameter int PAGE_BITS = 10) (
  input wire logic i_clock,
  input wire logic i_nrst,
  input fepseq_pkg::fepseq_arr_req_t i_req,
  input wire logic [3:0] i_lat,
  input wire logic i_fail,
  output fepseq_pkg::fepseq_arr_rsp_t o_rsp
);
  import fepseq_pkg::*;
  logic [15:0] mem [logic [18:0]];
  logic [18:0] dq [$];
  fepseq_arr_req_t cur;
  logic [3:0] cnt;
  // unwritten words read as ones
  function automatic logic [15:0] rd(input logic [18:0] k);
    return mem.exists(k) ? mem[k] : 16'hFFFF;
  endfunction
  // finish the pending operation on the array contents
  task finish_op();
    logic [18:0] k;
    logic b;
    k = {cur.info, cur.info ? {10'h000, cur.addr[7:1], 1'b0} : {cur.addr[17:1], 1'b0}};
    b = cur.info ? cur.addr[7] : cur.addr[17];
    dq.delete();
    o_rsp.done <= 1'b1;
    o_rsp.fail <= i_fail;
    o_rsp.rdata <= rd(k);
    if (cur.op == FEPSEQ_OP_PROG) mem[k] = rd(k) & cur.wdata;  // programming only clears bits
    foreach (mem[j]) begin
      if (cur.op == FEPSEQ_OP_PERASE && !j[18] && j[17:PAGE_BITS] == k[17:PAGE_BITS]) dq.push_back(j);
      if (cur.op == FEPSEQ_OP_MERASE && ((!j[18] && j[17] == b) || (cur.info && j[18] && j[7] == b))) dq.push_back(j);
    end
    foreach (dq[i]) mem.delete(dq[i]);
  endtask
  // one operation at a time, done after the chosen latency
  always @(posedge i_clock) begin
    o_rsp.done <= 1'b0;
    o_rsp.fail <= 1'b0;
    o_rsp.rdata <= ~o_rsp.rdata;  // data is garbage outside done
    if (!i_nrst) begin
      o_rsp <= '0;
      cnt <= 4'h0;
    end else if (i_req.valid) begin
      cur <= i_req;
      cnt <= i_lat;
    end else if (cnt != 4'h0) begin
      cnt <= cnt - 4'h1;
      if (cnt == 4'h1) finish_op();
    end
  end
endmodule

// *** verification/fepseq_sva.sv ***
`timescale 1ns/1ns
module fepseq_sva (
  input logic i_clock,
  input logic i_nrst,
  input fepseq_pkg::fepseq_arr_rsp_t [1:0] i_arr,
  input fepseq_pkg::fepseq_arr_req_t [1:0] o_arr,
  input fepseq_pkg::fepseq_boot_t o_boot
);
  import fepseq_pkg::*;
  logic [1:0] run;
  logic got;
  logic [15:0] prot;
  logic lock;
  logic [1:0] wr_op;
  // write lock is a majority of clear bits in the loaded protection word
  assign lock = !((prot[14] & prot[13]) | (prot[14] & prot[12]) | (prot[13] & prot[12]));
  assign wr_op[0] = o_arr[0].valid && o_arr[0].op != FEPSEQ_OP_READ;
  assign wr_op[1] = o_arr[1].valid && o_arr[1].op != FEPSEQ_OP_READ;
  // track array activity and capture the first protection word after reset
  always_ff @(posedge i_clock) begin
    if (!i_nrst) begin
      run <= 2'h0;
      got <= 1'b0;
      prot <= 16'h0000;
    end else begin
      for (int f = 0; f < 2; f++) begin
        if (o_arr[f].valid) run[f] <= 1'b1;
        else if (i_arr[f].done) run[f] <= 1'b0;
      end
      if (!got && i_arr[0].done && o_arr[0].addr[7:0] == FEPSEQ_PROT_WORD_ADDR) begin
        prot <= i_arr[0].rdata;
        got <= 1'b1;
      end
    end
  end
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_nrst);
  a_load_func: assert property ($rose(i_nrst) |-> ##[1:2] o_arr[0].valid && o_arr[0].info
    && o_arr[0].op == FEPSEQ_OP_READ && o_arr[0].addr[7:0] == FEPSEQ_FUNC_WORD_ADDR) else $error("no function load");
  a_prog_rd_gate: assert property (o_arr[0].valid && o_arr[0].op == FEPSEQ_OP_READ |-> !run[0])
    else $error("program read while busy");
  a_data_rd_gate: assert property (o_arr[1].valid && o_arr[1].op == FEPSEQ_OP_READ |-> run == 2'h0)
    else $error("data read while busy");
  a_info0_safe: assert property (wr_op[0] && o_arr[0].info |-> o_arr[0].addr[7])
    else $error("info block zero altered");
  a_info_no_page: assert property (o_arr[0].valid && o_arr[0].info |-> o_arr[0].op != FEPSEQ_OP_PERASE)
    else $error("info page erase");
  a_prog_align: assert property (wr_op[0] && o_arr[0].op == FEPSEQ_OP_PROG |-> !o_arr[0].addr[0])
    else $error("odd program address");
  a_lock_blocks: assert property (wr_op != 2'h0 |-> !lock)
    else $error("array write under lock");
  a_boot_safe: assert property (wr_op[0] && !o_arr[0].info && !o_arr[0].addr[17] |->
    (o_arr[0].op == FEPSEQ_OP_MERASE) ? prot[2:0] == 3'h7 : o_arr[0].addr[16:0] >= {4'h0, ~prot[2:0], 10'h000})
    else $error("boot area altered");
  a_start_range: assert property (o_boot.start_addr[23:13] == 11'h000 && o_boot.start_addr[9:0] == 10'h000)
    else $error("bad start address");
  a_isp_hold: assert property (got && o_boot.isp_mode && prot[2:0] == 3'h7 |-> o_boot.hold_reset)
    else $error("cpu released without boot area");
  c_page: cover property (o_arr[0].valid && o_arr[0].op == FEPSEQ_OP_PERASE);
  c_info_erase: cover property (o_arr[0].valid && o_arr[0].info && o_arr[0].op == FEPSEQ_OP_MERASE);
  c_held: cover property (o_boot.isp_mode && o_boot.hold_reset);
endmodule
bind fepseq_top fepseq_sva i_fepseq_sva (.i_clock(i_clock), .i_nrst(i_nrst), .i_arr(i_arr), .o_arr(o_arr),
  .o_boot(o_boot));

// *** verification/fepseq_tb.sv ***
`timescale 1ns/1ns
module tb_top;
  import fepseq_pkg::*;
  logic i_clock = 1'b0;
  logic i_nrst = 1'b0;
  fepseq_bus_req_t i_bus = '0;
  fepseq_bus_rsp_t o_bus;
  wire fepseq_arr_rsp_t [1:0] i_arr;
  fepseq_arr_req_t [1:0] o_arr;
  fepseq_boot_t o_boot;
  logic sel_lo = 1'b0;
  logic sel_hi = 1'b1;
  logic dbg = 1'b0;
  logic [3:0] lat = 4'h1;
  logic [1:0] fail = 2'h0;
  logic [31:0] notes [$];
  logic [31:0] seed = 32'h000158DD;
  logic [15:0] r;
  logic [15:0] w0;
  logic [15:0] w1;
  int n_errors = 0;
  int total_checks = 0;
  int cycles = 0;
  always #5 i_clock = ~i_clock;
  fepseq_top i_fepseq_top (.i_clock(i_clock), .i_nrst(i_nrst), .i_bus(i_bus), .o_bus(o_bus), .i_arr(i_arr),
    .o_arr(o_arr), .i_boot_select_low(sel_lo), .i_boot_select_high(sel_hi), .i_debug_boot_mode(dbg), .o_boot(o_boot));
  fepseq_flash_model #(.PAGE_BITS(10)) i_prog_array (.i_clock(i_clock), .i_nrst(i_nrst), .i_req(o_arr[0]),
    .i_lat(lat), .i_fail(fail[0]), .o_rsp(i_arr[0]));
  fepseq_flash_model #(.PAGE_BITS(9)) i_data_array (.i_clock(i_clock), .i_nrst(i_nrst), .i_req(o_arr[1]),
    .i_lat(lat), .i_fail(fail[1]), .o_rsp(i_arr[1]));
  function logic [15:0] rnd();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed[15:0];
  endfunction
  function automatic logic [23:0] ra(input logic f, input logic [7:0] o);
    return {f ? FEPSEQ_REG_PAGE_DATA : FEPSEQ_REG_PAGE_PROG, o};
  endfunction
  task automatic chk(input logic [31:0] g, input logic [31:0] e, input string s);
    total_checks++;
    if (g !== e) begin
      n_errors++;
      $display("[ERR] %0t %s got %h exp %h", $time, s, g, e);
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // one bus cycle: note the expectation, hold the request until ack
  task automatic acc(input logic we, input logic bt, input logic [23:0] a, input logic [15:0] d,
                     input logic [15:0] e, input logic [15:0] m, output logic [15:0] q);
    int k;
    notes.push_back({m, e});
    @(negedge i_clock);
    i_bus <= '{req: 1'b1, we: we, byte_rd: bt, addr: a, wdata: d};
    k = 0;
    do begin
      @(posedge i_clock);
      k++;
    end while (o_bus.ack !== 1'b1 && k < 300);
    q = o_bus.rdata;
    if (k >= 300) chk(32'h0, 32'h1, "no ack");
    @(negedge i_clock);
    i_bus.req <= 1'b0;
  endtask
  task automatic wr(input logic [23:0] a, input logic [15:0] d);
    acc(1'b1, 1'b0, a, d, 16'h0000, 16'h0000, r);
  endtask
  task automatic rd(input logic [23:0] a, input logic [15:0] e);
    acc(1'b0, 1'b0, a, 16'h0000, e, 16'hFFFF, r);
  endtask
  // poll the status busy bit of one flash
  task automatic idle(input logic f);
    int k;
    k = 0;
    do begin
      acc(1'b0, 1'b0, ra(f, FEPSEQ_OFS_STAT), 16'h0000, 16'h0000, 16'h0000, r);
      k++;
    end while (r[0] !== 1'b0 && k < 50);
  endtask
  task automatic restart(input logic lo, input logic hi, input logic dg);
    @(negedge i_clock);
    i_nrst <= 1'b0;
    sel_lo <= lo;
    sel_hi <= hi;
    dbg <= dg;
    repeat (6) @(negedge i_clock);
    i_nrst <= 1'b1;
  endtask
  // compare each answer with the oldest note
  always @(posedge i_clock) begin
    logic [31:0] nt;
    if (o_bus.ack === 1'b1 && notes.size() > 0) begin
      nt = notes.pop_front();
      if (nt[31:16] != 16'h0000) chk({16'h0, o_bus.rdata & nt[31:16]}, {16'h0, nt[15:0]}, "read data");
    end
  end
  // cut a hang short
  always @(posedge i_clock) begin
    cycles++;
    if (cycles == 20000) begin
      n_errors++;
      $display("[ERR] %0t timeout", $time);
      print_verdict();
    end
  end
  initial begin
    i_prog_array.mem[19'h400FE] = 16'h7FC6;
    i_prog_array.mem[19'h4007E] = 16'hA5C3;
    restart(1'b0, 1'b1, 1'b0);
    rd(ra(0, FEPSEQ_OFS_AR0), 16'hA5C3);
    rd(ra(0, FEPSEQ_OFS_AR1), 16'h7FC6);
    chk({6'h00, o_boot}, 32'h01000400, "boot");
    wr(ra(0, FEPSEQ_OFS_WER0), 16'hFFFF);
    wr(ra(0, FEPSEQ_OFS_WER1), 16'hFFFF);
    wr(ra(1, FEPSEQ_OFS_WER0), 16'hFFFF);
    wr(ra(0, FEPSEQ_OFS_IBAR), 16'h007F);
    rd(ra(0, FEPSEQ_OFS_IBAR), 16'h007E);
    rd(ra(0, FEPSEQ_OFS_IBDR), 16'hA5C3);
    rd(ra(1, FEPSEQ_OFS_AR1), 16'h0000);
    rd(24'hFFF9FE, 16'h0000);
    $display("test boot and registers done");
    lat <= 4'hC;
    w0 = rnd();
    w1 = rnd();
    wr(ra(0, FEPSEQ_OFS_CTRL), 16'h0001);
    wr(24'h0203FE, w0);
    wr(24'h020400, w1);
    rd(ra(0, FEPSEQ_OFS_STAT), 16'h0003);
    idle(1'b0);
    rd(24'h0203FE, w0);
    acc(1'b0, 1'b1, 24'h020401, 16'h0000, {8'h00, w1[15:8]}, 16'h00FF, r);
    wr(24'h000100, 16'h0000);
    rd(ra(0, FEPSEQ_OFS_STAT), 16'h0008);
    rd(24'h000100, 16'hFFFF);
    wr(ra(0, FEPSEQ_OFS_STAT), 16'h000C);
    $display("test program done");
    lat <= 4'h1;
    wr(ra(0, FEPSEQ_OFS_CTRL), 16'h0002);
    wr(24'h020002, 16'h1234);
    idle(1'b0);
    rd(24'h0203FE, 16'hFFFF);
    rd(24'h020400, w1);
    wr(ra(0, FEPSEQ_OFS_CTRL), 16'h0004);
    wr(24'h000800, 16'h0000);
    rd(ra(0, FEPSEQ_OFS_STAT), 16'h0004);
    wr(ra(0, FEPSEQ_OFS_STAT), 16'h000C);
    wr(ra(0, FEPSEQ_OFS_IBAR), 16'h0080);
    wr(ra(0, FEPSEQ_OFS_IBDR), 16'h0000);
    idle(1'b0);
    rd(24'h020400, 16'hFFFF);
    rd(ra(0, FEPSEQ_OFS_AR1), 16'h7FC6);
    wr(ra(0, FEPSEQ_OFS_CTRL), 16'h0002);
    wr(ra(0, FEPSEQ_OFS_IBDR), 16'h0000);
    wr(ra(0, FEPSEQ_OFS_CTRL), 16'h0001);
    wr(ra(0, FEPSEQ_OFS_IBAR), 16'h0010);
    wr(ra(0, FEPSEQ_OFS_IBDR), 16'h0000);
    rd(ra(0, FEPSEQ_OFS_STAT), 16'h000C);
    $display("test erase done");
    w0 = rnd();
    wr(ra(1, FEPSEQ_OFS_CTRL), 16'h0001);
    wr(24'h0E0010, w0);
    idle(1'b1);
    rd(24'h0E0010, w0);
    acc(1'b0, 1'b1, 24'h0E0010, 16'h0000, {8'h00, w0[7:0]}, 16'h00FF, r);
    wr(ra(1, FEPSEQ_OFS_IBAR), 16'h0011);
    rd(ra(1, FEPSEQ_OFS_IBDR), 16'hFFFF);
    fail[1] <= 1'b1;
    wr(ra(1, FEPSEQ_OFS_CTRL), 16'h0002);
    wr(24'h0E0200, 16'h0000);
    idle(1'b1);
    rd(ra(1, FEPSEQ_OFS_STAT), 16'h0004);
    fail[1] <= 1'b0;
    rd(24'h0E0010, w0);
    $display("test data flash done");
    restart(1'b1, 1'b1, 1'b0);
    rd(ra(0, FEPSEQ_OFS_AR1), 16'hFFFF);
    chk({6'h00, o_boot}, 32'h03000000, "boot");
    restart(1'b1, 1'b1, 1'b1);
    rd(ra(0, FEPSEQ_OFS_AR0), 16'hA5C3);
    chk({6'h00, o_boot}, 32'h00000000, "boot");
    $display("test restart done");
    print_verdict();
  end
endmodule
